// ==== core/flash_host_pkg.sv ====
// Constants, codes and carrier types for the flash command sequencer
package flash_host_pkg;
    localparam int ADDR_W = 26;
    localparam int DQ_W   = 16;
    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 26'h0000555;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 26'h00002aa;
    localparam logic [DQ_W-1:0] UNLOCK1_DATA   = 16'h00aa;
    localparam logic [DQ_W-1:0] UNLOCK2_DATA   = 16'h0055;
    localparam logic [DQ_W-1:0] BYPASS_ENTER   = 16'h0020;
    localparam logic [DQ_W-1:0] BYPASS_PROG    = 16'h00a0;
    localparam logic [DQ_W-1:0] BYPASS_EXIT1   = 16'h0090;
    localparam logic [DQ_W-1:0] BYPASS_EXIT2   = 16'h0000;
    localparam logic [DQ_W-1:0] BUF_LOAD_CODE  = 16'h0025;
    localparam logic [DQ_W-1:0] BUF_CONFIRM    = 16'h0029;
    localparam logic [DQ_W-1:0] PROG_SUSPEND   = 16'h0051;
    localparam logic [DQ_W-1:0] PROG_RESUME    = 16'h0050;
    localparam logic [DQ_W-1:0] ABORT_RESET    = 16'h00f0;
    // Timing at a 125 MHz core clock
    localparam int CLK_PERIOD_NS     = 8;
    localparam int WE_LOW_NS         = 40;
    localparam int WE_LOW_CYC        = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_RESUME_NS     = 5000;
    localparam int RESUME_CYC        = (MIN_RESUME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Sequence step indices
    localparam logic [2:0] STEP_UNLOCK1 = 3'h0;
    localparam logic [2:0] STEP_UNLOCK2 = 3'h1;
    localparam logic [2:0] STEP_CODE    = 3'h2;
    localparam logic [2:0] STEP_COUNT   = 3'h3;
    localparam logic [2:0] STEP_DATA    = 3'h4;
    localparam logic [2:0] STEP_CONFIRM = 3'h5;

    typedef enum logic [3:0] {
        OP_ENTRY  = 4'h0,
        OP_PROG   = 4'h1,
        OP_EXIT   = 4'h2,
        OP_BUF    = 4'h3,
        OP_SUSP   = 4'h4,
        OP_RESUME = 4'h5,
        OP_ABORT  = 4'h6,
        OP_ACC_ON = 4'h7,
        OP_ACC_OFF= 4'h8
    } op_e;

    typedef struct packed {
        op_e               op;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0]   data;
    } cmd_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0]   data;
    } word_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0]   dq;
        logic              dq_oe;
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
    } pins_s;
endpackage

// ==== core/flash_host_seq.sv ====
// Host-side write-cycle sequencer for a parallel NOR flash
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Host suspends with 51h and resumes with 50h only.
// - Host waits the minimum resume interval before its next suspend.
// - Host sends full three-cycle abort reset, unlocks included, in bypass.
// - Host raises accelerate only once target sectors are unprotected.
// - Buffer load: 25h@sector, count minus one, data, 29h@sector.
module flash_host_seq
(
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       cmd_valid_i,
    input  wire flash_host_pkg::cmd_s       cmd_i,
    output logic                            cmd_ready_o,
    output logic                            cmd_err_o,
    output logic                            done_o,
    input  wire logic                       wd_valid_i,
    input  wire flash_host_pkg::word_s      wd_i,
    output logic                            wd_ready_o,
    input  wire logic                       sectors_unlocked_i,
    input  wire logic                       flash_ready_i,
    output flash_host_pkg::pins_s           pins_o,
    output logic                            acc_hv_o,
    output logic                            bypass_o,
    output logic                            suspended_o
);
    import flash_host_pkg::*;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_PULSE = 2'b10,
        ST_HOLD  = 2'b11
    } state_e;

    state_e          state_q;
    cmd_s            cmd_q;
    logic [2:0]      step_q;
    logic [7:0]      left_q;
    logic [3:0]      we_cnt_q;
    logic [15:0]     gap_q;
    logic            byp_q;
    logic            acc_q;
    logic            susp_q;
    logic            rdy_m_q;
    logic            rdy_s_q;
    logic            ready_q;
    logic            wd_ready_q;
    pins_s           pins_q;

    // Ready/busy pin is asynchronous to the core clock
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            {rdy_s_q, rdy_m_q} <= 2'b11;
        else
            {rdy_s_q, rdy_m_q} <= {rdy_m_q, flash_ready_i};
    end

    wire flash_busy = !rdy_s_q;
    wire eff_byp    = byp_q | acc_q;
    wire take       = cmd_valid_i & ready_q;

    wire legal =
        (cmd_i.op == OP_ENTRY)   ? (!eff_byp && !susp_q) :
        (cmd_i.op == OP_PROG)    ? (eff_byp && !susp_q) :
        (cmd_i.op == OP_EXIT)    ? (byp_q && !acc_q && !susp_q) :
        (cmd_i.op == OP_BUF)     ? !susp_q :
        (cmd_i.op == OP_SUSP)    ? (!susp_q && flash_busy && gap_q == 16'h0000) :
        (cmd_i.op == OP_RESUME)  ? susp_q :
        (cmd_i.op == OP_ABORT)   ? 1'b1 :
        (cmd_i.op == OP_ACC_ON)  ? (!acc_q && sectors_unlocked_i && !susp_q) :
        (cmd_i.op == OP_ACC_OFF) ? (acc_q && !flash_busy) : 1'b0;

    wire pin_op     = legal && cmd_i.op != OP_ACC_ON && cmd_i.op != OP_ACC_OFF;
    // buffer load skips unlocks in bypass
    wire [2:0] first_step =
        (cmd_i.op == OP_BUF && eff_byp) ? STEP_CODE :
        (cmd_i.op == OP_BUF || cmd_i.op == OP_ENTRY || cmd_i.op == OP_ABORT) ?
        STEP_UNLOCK1 : STEP_CODE;

    // Address and data of the current step
    wire is_unlock  = step_q == STEP_UNLOCK1 || step_q == STEP_UNLOCK2;
    wire is_data    = cmd_q.op == OP_BUF && step_q == STEP_DATA;
    wire [ADDR_W-1:0] step_addr =
        (step_q == STEP_UNLOCK1) ? UNLOCK1_ADDR :
        (step_q == STEP_UNLOCK2) ? UNLOCK2_ADDR :
        (cmd_q.op == OP_ENTRY || cmd_q.op == OP_ABORT) ? UNLOCK1_ADDR : cmd_q.addr;
    wire [DQ_W-1:0] step_data =
        (step_q == STEP_UNLOCK1) ? UNLOCK1_DATA :
        (step_q == STEP_UNLOCK2) ? UNLOCK2_DATA :
        (cmd_q.op == OP_ENTRY)   ? BYPASS_ENTER :
        (cmd_q.op == OP_PROG)    ? ((step_q == STEP_CODE) ? BYPASS_PROG : cmd_q.data) :
        (cmd_q.op == OP_EXIT)    ? ((step_q == STEP_CODE) ? BYPASS_EXIT1 : BYPASS_EXIT2) :
        (cmd_q.op == OP_SUSP)    ? PROG_SUSPEND :
        (cmd_q.op == OP_RESUME)  ? PROG_RESUME :
        (cmd_q.op == OP_ABORT)   ? ABORT_RESET :
        (step_q == STEP_CODE)    ? BUF_LOAD_CODE :
        (step_q == STEP_COUNT)   ? {8'h00, cmd_q.data[7:0]} : BUF_CONFIRM;
    wire two_cycle  = cmd_q.op == OP_PROG || cmd_q.op == OP_EXIT;
    wire step_last  =
        (cmd_q.op == OP_BUF) ? step_q == STEP_CONFIRM :
        two_cycle ? step_q == STEP_COUNT :
        !is_unlock;
    wire [2:0] next_step =
        (is_data && left_q != 8'h00) ? STEP_DATA : 3'(step_q + 3'h1);
    wire pulse_end  = we_cnt_q == 4'(WE_LOW_CYC - 1);
    wire op_end     = state_q == ST_HOLD && step_last;
    wire word_take  = is_data && wd_ready_q && wd_valid_i;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q    <= ST_IDLE;
            cmd_q      <= '0;
            step_q     <= STEP_UNLOCK1;
            left_q     <= 8'h00;
            we_cnt_q   <= 4'h0;
            ready_q    <= 1'b1;
            wd_ready_q <= 1'b0;
            pins_q     <= {{ADDR_W{1'b0}}, {DQ_W{1'b0}}, 4'b0111};
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (take && pin_op)
                    begin
                        cmd_q   <= cmd_i;
                        step_q  <= first_step;
                        left_q  <= cmd_i.data[7:0];
                        ready_q <= 1'b0;
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    if (!is_data)
                    begin
                        // Strobe stays high so address and data settle before it falls
                        pins_q  <= {step_addr, step_data, 4'b1011};
                        state_q <= ST_PULSE;
                    end
                    else if (word_take)
                    begin
                        pins_q     <= {wd_i.addr, wd_i.data, 4'b1011};
                        wd_ready_q <= 1'b0;
                        state_q    <= ST_PULSE;
                    end
                    else
                        wd_ready_q <= 1'b1;
                end
                ST_PULSE:
                begin
                    pins_q.we_n <= 1'b0;
                    if (pins_q.we_n == 1'b0)
                        we_cnt_q <= 4'(we_cnt_q + 4'h1);
                    if (pins_q.we_n == 1'b0 && pulse_end)
                    begin
                        pins_q.we_n <= 1'b1;
                        we_cnt_q    <= 4'h0;
                        state_q     <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    if (step_last)
                    begin
                        pins_q.ce_n  <= 1'b1;
                        pins_q.dq_oe <= 1'b0;
                        ready_q      <= 1'b1;
                        state_q      <= ST_IDLE;
                    end
                    else
                    begin
                        if (is_data)
                            left_q <= 8'(left_q - 8'h01);
                        step_q  <= next_step;
                        state_q <= ST_SETUP;
                    end
                end
            endcase
        end
    end

    // Mode tracking; resume gap counter
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            byp_q     <= 1'b0;
            acc_q     <= 1'b0;
            susp_q    <= 1'b0;
            gap_q     <= 16'h0000;
            done_o    <= 1'b0;
            cmd_err_o <= 1'b0;
        end
        else
        begin
            done_o    <= op_end || (take && legal && !pin_op);
            cmd_err_o <= take && !legal;
            if (take && legal && !pin_op)
                acc_q <= cmd_i.op == OP_ACC_ON;
            if (op_end && (cmd_q.op == OP_ENTRY || cmd_q.op == OP_EXIT))
                byp_q <= cmd_q.op == OP_ENTRY;
            if (op_end && (cmd_q.op == OP_SUSP || cmd_q.op == OP_RESUME))
                susp_q <= cmd_q.op == OP_SUSP;
            if (op_end && cmd_q.op == OP_RESUME)
                gap_q <= 16'(RESUME_CYC);
            else if (gap_q != 16'h0000)
                gap_q <= 16'(gap_q - 16'h0001);
        end
    end

    assign pins_o      = pins_q;
    assign cmd_ready_o = ready_q;
    assign wd_ready_o  = wd_ready_q;
    assign acc_hv_o    = acc_q;
    assign bypass_o    = byp_q;
    assign suspended_o = susp_q;

    // Helper: write pulses in the current operation
    logic [3:0] npulse_q;
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            npulse_q <= 4'h0;
        else if (state_q == ST_IDLE)
            npulse_q <= 4'h0;
        else if (state_q == ST_HOLD)
            npulse_q <= 4'(npulse_q + 4'h1);
    end

    a_susp_code: assert property (
        (state_q == ST_PULSE && cmd_q.op == OP_SUSP) |-> pins_q.dq == 16'h0051)
        else $error("suspend written with wrong code");
    a_resume_code: assert property (
        (state_q == ST_PULSE && cmd_q.op == OP_RESUME) |-> pins_q.dq == 16'h0050)
        else $error("resume written with wrong code");
    a_resume_gap_held: assert property (
        (op_end && cmd_q.op == OP_RESUME) |=> (gap_q != 16'h0000)[*8])
        else $error("resume gap not held");
    a_abort_three_cycles: assert property (
        (op_end && cmd_q.op == OP_ABORT) |-> npulse_q == 4'h2 && pins_q.dq == 16'h00f0)
        else $error("abort reset not three cycles");
    a_acc_unlocked_first: assert property (
        $rose(acc_hv_o) |-> $past(sectors_unlocked_i))
        else $error("accelerate raised while sectors protected");
    a_buf_confirm_last: assert property (
        (op_end && cmd_q.op == OP_BUF) |-> pins_q.dq == 16'h0029 && pins_q.addr == cmd_q.addr)
        else $error("buffer load not closed by confirm");
    a_we_low_width: assert property (
        $fell(pins_q.we_n) |-> !pins_q.we_n[*5] ##1 pins_q.we_n)
        else $error("write pulse width wrong");

    c_bypass_entry: cover property (op_end && cmd_q.op == OP_ENTRY);
    c_buffer_load: cover property (op_end && cmd_q.op == OP_BUF && eff_byp);
    c_suspend_resume: cover property (op_end && cmd_q.op == OP_RESUME);
    c_refused: cover property (cmd_err_o);
endmodule // flash_host_seq

`default_nettype wire

// ==== sim/flash_dev_model.sv ====
// Behavioural flash device that answers the sequencer's write cycles
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter int PROG_CYC = 3000,
    parameter int SECT_LSB = 16
)
(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire pins_s  pins_i,
    input  wire logic   acc_i,
    output logic        ready_o,
    output logic        bypass_o,
    output logic        susp_o,
    output logic [15:0] n_wr_o,
    output word_s       last_o
);
    localparam logic [15:0] BUSY = 16'(PROG_CYC);
    logic                     we_q, mode_q, setup_q, exit_q;
    logic [1:0]               unl_q, buf_q;
    logic [7:0]               left_q;
    logic [ADDR_W-1:SECT_LSB] sa_q;
    logic [15:0]              busy_q;
    wire logic [ADDR_W-1:0]   a = pins_i.addr;
    wire logic [DQ_W-1:0]     d = pins_i.dq;
    // Write latched when WE rises with the chip still selected
    wire logic                wr = !we_q && pins_i.we_n && !pins_i.ce_n;
    assign bypass_o = mode_q | acc_i;
    assign ready_o  = (busy_q == 16'h0) || susp_o;
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            {we_q, mode_q, setup_q, exit_q, susp_o} <= 5'b10000;
            {unl_q, buf_q, left_q, sa_q, busy_q} <= '0;
            n_wr_o <= '0;
            last_o <= '0;
        end
        else
        begin
            we_q <= pins_i.we_n;
            if (busy_q != 16'h0 && !susp_o)
                busy_q <= busy_q - 16'h1;
            if (wr)
            begin
                n_wr_o <= n_wr_o + 16'h1;
                last_o <= '{a, d};
                // no erase suspend or overlay state exists, so suspend stays open
                // only suspend or resume around a program
                if (susp_o || busy_q != 16'h0)
                    susp_o <= susp_o ? !(d == PROG_RESUME || d == 16'h0030)
                                     : (d == PROG_SUSPEND || d == 16'h00b0);
                else if (buf_q == 2'h1)
                    {buf_q, left_q} <= {2'h2, d[7:0]};
                else if (buf_q == 2'h2)
                    {buf_q, left_q} <= {(left_q == 8'h0) ? 2'h3 : 2'h2, left_q - 8'h1};
                else if (buf_q == 2'h3)
                    {buf_q, busy_q} <= {2'h0, (d == BUF_CONFIRM && a[ADDR_W-1:SECT_LSB] == sa_q)
                                              ? BUSY : 16'h0};
                else if (setup_q)
                    {setup_q, busy_q} <= {1'b0, BUSY};
                else if (exit_q)
                    {exit_q, mode_q} <= {1'b0, mode_q & (d != BYPASS_EXIT2)};
                else if (unl_q == 2'h2)
                begin
                    unl_q  <= 2'h0;
                    mode_q <= mode_q | (d == BYPASS_ENTER);
                    if (d == BUF_LOAD_CODE)
                        {buf_q, sa_q} <= {2'h1, a[ADDR_W-1:SECT_LSB]};
                end
                else if (bypass_o && d == BYPASS_PROG)
                    setup_q <= 1'b1;
                else if (bypass_o && d == BYPASS_EXIT1)
                    exit_q <= 1'b1;
                else if (bypass_o && d == BUF_LOAD_CODE)
                    {buf_q, sa_q} <= {2'h1, a[ADDR_W-1:SECT_LSB]};
                else if (d == UNLOCK1_DATA && a == UNLOCK1_ADDR)
                    unl_q <= 2'h1;
                else
                    unl_q <= (unl_q == 2'h1 && d == UNLOCK2_DATA && a == UNLOCK2_ADDR) ? 2'h2 : 2'h0;
            end
        end
    end
endmodule // flash_dev_model
`default_nettype wire

// ==== sim/tb_flash_host_seq.sv ====
// Self-checking bench for the host flash sequencer against a device model
`timescale 1ns/10ps
`default_nettype none
module tb_flash_host_seq;
    import flash_host_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cmd_valid_i = 1'b0;
    cmd_s        cmd_i = '0;
    logic        wd_valid_i = 1'b0;
    word_s       wd_i = '0;
    logic        sectors_unlocked_i = 1'b0;
    logic        cmd_ready_o, cmd_err_o, done_o, wd_ready_o, flash_ready_i;
    logic        acc_hv_o, bypass_o, suspended_o, m_byp, m_susp;
    pins_s       pins_o;
    word_s       last;
    logic [15:0] n_wr, base;
    int          n_errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          wd_idx = 0;
    int          wd_n = 0;

    always #4 core_clk_i = ~core_clk_i;

    flash_host_seq dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .cmd_err_o(cmd_err_o), .done_o(done_o),
        .wd_valid_i(wd_valid_i), .wd_i(wd_i), .wd_ready_o(wd_ready_o),
        .sectors_unlocked_i(sectors_unlocked_i), .flash_ready_i(flash_ready_i),
        .pins_o(pins_o), .acc_hv_o(acc_hv_o), .bypass_o(bypass_o), .suspended_o(suspended_o));
    flash_dev_model #(.PROG_CYC(3000)) dev (.clk_i(core_clk_i), .rst_i(rst_i), .pins_i(pins_o),
        .acc_i(acc_hv_o), .ready_o(flash_ready_i), .bypass_o(m_byp), .susp_o(m_susp),
        .n_wr_o(n_wr), .last_o(last));

    // Buffer words stay on offer until taken; the cycle ceiling cuts a hang short
    always @(posedge core_clk_i)
    begin
        if (wd_valid_i && wd_ready_o)
            wd_idx = wd_idx + 1;
        wd_valid_i <= (wd_idx < wd_n);
        wd_i       <= '{26'h0031000 + 26'(wd_idx), 16'h1000 + 16'(wd_idx)};
        cycles = cycles + 1;
        if (cycles == 40000)
        begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic miss(input logic bad, input string what);
        comparisons++;
        if (bad)
        begin
            n_errors++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        miss(got !== exp, what);
    endtask
    task automatic chk_word(input word_s got, input word_s exp, input string what);
        miss(got !== exp, what);
    endtask
    task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp, input string what);
        miss(got !== exp, what);
    endtask

    // Holds the request until taken, then waits for done or refusal
    task automatic issue(input op_e op, input logic [25:0] a, input logic [15:0] d,
                         input logic exp_err);
        int t;
        @(posedge core_clk_i);
        cmd_valid_i <= 1'b1;
        cmd_i       <= '{op, a, d};
        do
            @(posedge core_clk_i);
        while (cmd_ready_o !== 1'b1);
        cmd_valid_i <= 1'b0;
        for (t = 0; t < 2000; t++)
        begin
            #1;
            if (cmd_err_o === 1'b1 || done_o === 1'b1)
                break;
            @(posedge core_clk_i);
        end
        chk_bit(cmd_err_o, exp_err, "command refusal");
        chk_bit(done_o, ~exp_err, "command completion");
    endtask

    task automatic wait_ready();
        int t;
        for (t = 0; t < 5000 && flash_ready_i !== 1'b1; t++)
            @(posedge core_clk_i);
        repeat (4) @(posedge core_clk_i);
        #1;
        chk_bit(flash_ready_i, 1'b1, "device ready again");
    endtask

    task automatic t_reset();
        chk_bit(cmd_ready_o & pins_o.we_n & pins_o.ce_n & ~pins_o.dq_oe, 1'b1,
                "idle after reset");
        issue(OP_PROG, 26'h0000100, 16'h1234, 1'b1);
        issue(OP_RESUME, '0, '0, 1'b1);
        chk_cnt(n_wr, 16'h0, "refused commands wrote");
    endtask

    task automatic t_bypass_prog();
        base = n_wr;
        issue(OP_ENTRY, '0, '0, 1'b0);
        chk_cnt(n_wr, base + 16'h3, "entry write count");
        chk_word(last, '{UNLOCK1_ADDR, BYPASS_ENTER}, "entry last write");
        chk_bit(m_byp & bypass_o, 1'b1, "bypass not entered");
        issue(OP_ENTRY, '0, '0, 1'b1);
        issue(OP_PROG, 26'h0012345, 16'h5a5a, 1'b0);
        chk_cnt(n_wr, base + 16'h5, "program write count");
        chk_word(last, '{26'h0012345, 16'h5a5a}, "program target write");
        repeat (4) @(posedge core_clk_i);
        issue(OP_SUSP, 26'h0012345, '0, 1'b0);
        chk_word(last, '{26'h0012345, PROG_SUSPEND}, "suspend code");
        chk_bit(m_susp & suspended_o, 1'b1, "program not suspended");
        issue(OP_PROG, 26'h0012000, 16'h0001, 1'b1);
        issue(OP_SUSP, '0, '0, 1'b1);
        issue(OP_RESUME, 26'h0012345, '0, 1'b0);
        chk_word(last, '{26'h0012345, PROG_RESUME}, "resume code");
        chk_bit(m_susp | suspended_o, 1'b0, "program not resumed");
        issue(OP_RESUME, '0, '0, 1'b1);
        issue(OP_SUSP, '0, '0, 1'b1);
        repeat (RESUME_CYC) @(posedge core_clk_i);
        issue(OP_SUSP, '0, '0, 1'b0);
        issue(OP_RESUME, '0, '0, 1'b0);
    endtask

    task automatic t_exit();
        wait_ready();
        base = n_wr;
        issue(OP_EXIT, 26'h0012345, '0, 1'b0);
        chk_cnt(n_wr, base + 16'h2, "exit write count");
        chk_word(last, '{26'h0012345, BYPASS_EXIT2}, "exit second cycle");
        chk_bit(m_byp | bypass_o, 1'b0, "bypass not left");
        issue(OP_EXIT, '0, '0, 1'b1);
    endtask

    task automatic t_buf(input logic [15:0] n);
        base   = n_wr;
        wd_n   = wd_n + 2;
        issue(OP_BUF, 26'h0031234, 16'h0001, 1'b0);
        chk_cnt(n_wr, base + n, "buffer write count");
        chk_word(last, '{26'h0031234, BUF_CONFIRM}, "buffer confirm");
        repeat (4) @(posedge core_clk_i);
        #1;
        chk_bit(flash_ready_i, 1'b0, "buffer program not started");
        wait_ready();
    endtask

    task automatic t_acc();
        issue(OP_ACC_ON, '0, '0, 1'b1);
        @(posedge core_clk_i);
        sectors_unlocked_i <= 1'b1;
        issue(OP_ACC_ON, '0, '0, 1'b0);
        chk_bit(acc_hv_o & m_byp, 1'b1, "high voltage bypass");
        base = n_wr;
        issue(OP_PROG, 26'h0020000, 16'h00c3, 1'b0);
        chk_cnt(n_wr, base + 16'h2, "accelerated program writes");
        repeat (4) @(posedge core_clk_i);
        issue(OP_ACC_OFF, '0, '0, 1'b1);
        wait_ready();
        t_buf(16'h5);
        base = n_wr;
        issue(OP_ABORT, '0, '0, 1'b0);
        chk_cnt(n_wr, base + 16'h3, "abort writes");
        chk_word(last, '{UNLOCK1_ADDR, ABORT_RESET}, "abort third cycle");
        issue(OP_ACC_OFF, '0, '0, 1'b0);
        chk_bit(acc_hv_o | m_byp, 1'b0, "normal mode not restored");
    endtask

    initial
    begin
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        t_reset();
        t_bypass_prog();
        t_exit();
        t_buf(16'h7);
        t_acc();
        final_report();
    end
endmodule // tb_flash_host_seq
`default_nettype wire
